// File: verilog/pmc_pkg.sv
package pmc_pkg;

   // Clock and bus geometry
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          APB_AW         = 12;
   localparam int          APB_DW         = 32;

   // Register indices; byte address is four times the index
   localparam logic [9:0]  PWR_CTRL_IDX   = 10'h087;
   localparam logic [9:0]  SLEEP_CFG_IDX  = 10'h0BE;
   localparam logic [9:0]  CLK_CTRL_IDX   = 10'h040;

   // Power control register fields
   localparam int          TRIG_BIT       = 0;
   localparam int          RSVD_BIT       = 1;
   localparam int          SPARE_LSB      = 2;
   localparam logic [7:0]  PWR_CTRL_RST   = 8'h00;

   // Sleep configuration register fields
   localparam int          MODE_LSB       = 0;
   localparam int          OSC_PD_BIT     = 2;
   localparam int          RC_STB_BIT     = 5;
   localparam int          XTAL_STB_BIT   = 6;
   localparam logic [1:0]  MODE_RST       = 2'h0;
   localparam logic        OSC_PD_RST     = 1'h1;

   // Clock control register fields
   localparam int          OSC_SEL_BIT    = 0;
   localparam int          STATE_LSB      = 1;
   localparam int          CUR_MODE_LSB   = 4;
   localparam logic        OSC_SEL_RST    = 1'h1;

   // Power-mode field encoding
   localparam logic [1:0]  MODE_CPU_IDLE  = 2'h0;
   localparam logic [1:0]  MODE_LIGHT     = 2'h1;
   localparam logic [1:0]  MODE_DEEP      = 2'h2;
   localparam logic [1:0]  MODE_STANDBY   = 2'h3;

   // Power down/up sequence lengths
   localparam int          SEQ_W          = 8;
   localparam int          LIGHT_SEQ_NS   = 40;
   localparam int          DEEP_SEQ_NS    = 160;
   localparam int          LIGHT_SEQ_CYC  = (LIGHT_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          DEEP_SEQ_CYC   = (DEEP_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_CPU_IDLE,
      ST_PWR_DOWN,
      ST_SLEEP,
      ST_PWR_UP
   } pmc_state_e;

endpackage : pmc_pkg

// File: verilog/pmc_seq_timer.sv
`timescale 1ns/1ps
module pmc_seq_timer #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   // Sequence control
   input  wire logic         start,
   input  wire logic [W-1:0] length,
   output logic              done
);
   typedef struct packed {
      logic         busy;
      logic [W-1:0] cnt;
      logic         done;
   } pmc_tmr_s;

   pmc_tmr_s r_reg;
   pmc_tmr_s r_next;

   // A new start reloads the count and drops any sequence in flight
   always_comb begin
      r_next      = r_reg;
      r_next.done = 1'b0;
      if (start) begin
         r_next.busy = 1'b1;
         r_next.cnt  = length;
      end else if (r_reg.busy) begin
         if (r_reg.cnt <= W'(1)) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end else begin
            r_next.cnt = r_reg.cnt - W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign done = r_reg.done;

endmodule : pmc_seq_timer

// File: verilog/pmc_power_ctrl.sv
// Notes on behaviour
// RQ1: Active keeps regulator on, selected fast oscillator on, one slow oscillator on.
// RQ2: Trigger with CPU-idle mode gates only the CPU clock until interrupt.
// RQ3: Any enabled interrupt returns CPU-idle to active, resuming in place.
// RQ4: Light sleep stops both fast oscillators; regulator and slow oscillator stay.
// RQ5: Deep sleep also stops regulator; slow oscillator and timer wake stay.
// RQ6: Standby stops regulator and all oscillators; only port wake works.
// RQ7: I/O pins hold direction and level during light, deep and standby.
// RQ8: Port wake in any sleep, timer wake in light/deep, returns to active.
// RQ9: Reset returns every mode to active, restarting from the beginning.
// RQ10: Light sleep uses short down/up sequence; deep and standby use long.
// RQ11: Wake restarts the fast oscillators that ran before sleep.
// RQ12: With crystal selected, run from fast RC until crystal is stable.
// RQ13: Software sets mode field, then writes trigger; device enters that mode.
// RQ14: Wake clears the mode field and trigger while returning to active.
// RQ15: Nonzero mode field blocks port and sleep-timer interrupts.
// RQ16: Hardware clears mode field once the sleep mode is reached.
// RQ17: Software clears mode field before leaving any wake-capable handler.
// RQ18: Software disables non-wake interrupts first and triggers promptly.
// RQ19: Trigger always reads 0; any interrupt clears it, back to active.
// RQ20: Software must write 0 to power control bit 1, else CPU stops.
// RQ21: Register contents are kept across deep sleep and standby.
// RQ22: Deep sleep and standby discard USB state; avoid them with USB.
// RQ23: Mode field: 00 CPU idle, 01 light, 10 deep, 11 standby.
// RQ24: Wake during power-down aborts entry and returns to active.
`timescale 1ns/1ps
module pmc_power_ctrl
   import pmc_pkg::*;
#(
   parameter int LIGHT_CYC = LIGHT_SEQ_CYC,
   parameter int DEEP_CYC  = DEEP_SEQ_CYC
) (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       sys_rst,
   // APB slave
   input  wire logic [pmc_pkg::APB_AW-1:0] paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [pmc_pkg::APB_DW-1:0] pwdata,
   output logic      [pmc_pkg::APB_DW-1:0] prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Wake and interrupt sources
   input  wire logic                       ext_port_irq,
   input  wire logic                       sleep_timer_irq,
   input  wire logic                       any_irq,
   // Oscillator status and slow clock choice
   input  wire logic                       xtal_stable_flag,
   input  wire logic                       rc_stable_flag,
   input  wire logic                       slow_osc_sel,
   // Power and clock controls
   output logic                            cpu_clk_en,
   output logic                            fast_xtal_osc_en,
   output logic                            fast_rc_osc_en,
   output logic                            slow_rc_osc_en,
   output logic                            slow_xtal_osc_en,
   output logic                            regulator_en,
   output logic                            sys_clk_from_xtal,
   // Status toward the rest of the chip
   output logic                            io_hold,
   output logic                            wake_irq_block,
   output logic                            usb_state_clear,
   output logic                            cpu_idle_status
);
   import pmc_pkg::*;

   localparam logic [APB_AW-1:0] PWR_CTRL_ADDR  = {PWR_CTRL_IDX, 2'b00};
   localparam logic [APB_AW-1:0] SLEEP_CFG_ADDR = {SLEEP_CFG_IDX, 2'b00};
   localparam logic [APB_AW-1:0] CLK_CTRL_ADDR  = {CLK_CTRL_IDX, 2'b00};

   typedef struct packed {
      pmc_state_e         state;
      logic [1:0]         mode;
      logic [1:0]         cur_mode;
      logic               osc_pd;
      logic               osc_sel;
      logic [5:0]         spare;
      logic               rsvd;
      logic [APB_DW-1:0]  prdata;
      logic               pready;
      logic               pslverr;
      logic               cpu_clk_en;
      logic               xtal_en;
      logic               rc_en;
      logic               slow_rc_en;
      logic               slow_xtal_en;
      logic               regulator_en;
      logic               clk_xtal;
      logic               io_hold;
      logic               irq_block;
      logic               usb_clear;
      logic               idle_status;
   } pmc_ctrl_s;

   pmc_ctrl_s          r_reg;
   pmc_ctrl_s          r_next;
   logic               seq_start;
   logic [SEQ_W-1:0]   seq_len;
   logic               seq_done;
   logic               bus_access;
   logic               bus_write;
   logic               trig;
   logic               wake;
   logic               fast_on;

   function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
      if (a == PWR_CTRL_ADDR) begin
         return 1'b1;
      end else if (a == SLEEP_CFG_ADDR) begin
         return 1'b1;
      end else if (a == CLK_CTRL_ADDR) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction : addr_mapped

   function automatic logic [SEQ_W-1:0] seq_length(input logic [1:0] m);
      if (m == MODE_LIGHT) begin
         return SEQ_W'(LIGHT_CYC);                                   // see RQ10
      end else begin
         return SEQ_W'(DEEP_CYC);                                    // see RQ10
      end
   endfunction : seq_length

   function automatic logic [APB_DW-1:0] read_word(input logic [APB_AW-1:0] a, input pmc_ctrl_s s,
                                                   input logic xs, input logic rs);
      logic [APB_DW-1:0] w;
      w = '0;
      if (a == PWR_CTRL_ADDR) begin
         w[SPARE_LSB +: 6] = s.spare;
      end else if (a == SLEEP_CFG_ADDR) begin
         w[MODE_LSB +: 2]  = s.mode;
         w[OSC_PD_BIT]     = s.osc_pd;
         w[RC_STB_BIT]     = rs;
         w[XTAL_STB_BIT]   = xs;
      end else if (a == CLK_CTRL_ADDR) begin
         w[OSC_SEL_BIT]       = s.osc_sel;
         w[STATE_LSB +: 3]    = s.state;
         w[CUR_MODE_LSB +: 2] = s.cur_mode;
      end else begin
         w = '0;
      end
      return w;
   endfunction : read_word

   always_comb begin
      r_next         = r_reg;
      seq_start      = 1'b0;
      seq_len        = seq_length(r_reg.cur_mode);
      trig           = 1'b0;
      fast_on        = 1'b0;

      // APB: answer one cycle into the access phase; write lands with pready
      bus_access     = psel && penable;
      bus_write      = bus_access && r_reg.pready && pwrite && addr_mapped(paddr);
      r_next.pready  = 1'b0;
      r_next.pslverr = 1'b0;
      if (bus_access && !r_reg.pready) begin
         r_next.pready  = 1'b1;
         r_next.pslverr = !addr_mapped(paddr);
         r_next.prdata  = read_word(paddr, r_reg, xtal_stable_flag, rc_stable_flag); // see RQ19
      end

      if (bus_write) begin
         if (paddr == PWR_CTRL_ADDR) begin
            r_next.spare = pwdata[SPARE_LSB +: 6];
            r_next.rsvd  = pwdata[RSVD_BIT];                        // see RQ20
            trig         = pwdata[TRIG_BIT];                        // see RQ13
         end else if (paddr == SLEEP_CFG_ADDR) begin
            r_next.mode   = pwdata[MODE_LSB +: 2];                  // see RQ13
            r_next.osc_pd = pwdata[OSC_PD_BIT];
         end else if (paddr == CLK_CTRL_ADDR) begin
            r_next.osc_sel = pwdata[OSC_SEL_BIT];
            if (pwdata[OSC_SEL_BIT] != r_reg.osc_sel) begin
               r_next.osc_pd = 1'b0;
            end
         end
      end

      // Wake sources are sensed raw so that a wake during power-down aborts
      wake = ext_port_irq || (sleep_timer_irq && (r_reg.cur_mode != MODE_STANDBY)); // see RQ8 RQ23

      case (r_reg.state)
         ST_ACTIVE: begin
            if (trig) begin
               if (r_next.mode == MODE_CPU_IDLE) begin
                  r_next.state = ST_CPU_IDLE;                      // see RQ2
               end else begin
                  r_next.state    = ST_PWR_DOWN;                   // see RQ13
                  r_next.cur_mode = r_next.mode;
                  r_next.io_hold  = 1'b1;                          // see RQ7
                  seq_start       = 1'b1;                          // see RQ10
                  seq_len         = seq_length(r_next.mode);
               end
            end
         end
         ST_CPU_IDLE: begin
            if (any_irq) begin
               r_next.state = ST_ACTIVE;                           // see RQ3
            end
         end
         ST_PWR_DOWN: begin
            if (wake) begin
               r_next.state = ST_PWR_UP;                           // see RQ24
               r_next.mode  = MODE_CPU_IDLE;                       // see RQ14
               seq_start    = 1'b1;
            end else if (seq_done) begin
               r_next.state = ST_SLEEP;
               r_next.mode  = MODE_CPU_IDLE;                       // see RQ16
            end
         end
         ST_SLEEP: begin
            if (wake) begin
               r_next.state = ST_PWR_UP;                           // see RQ8
               r_next.mode  = MODE_CPU_IDLE;                       // see RQ14
               seq_start    = 1'b1;                                // see RQ10
            end
         end
         ST_PWR_UP: begin
            if (seq_done) begin
               r_next.state   = ST_ACTIVE;
               r_next.io_hold = 1'b0;
            end
         end
         default: begin
            r_next.state = ST_ACTIVE;
         end
      endcase

      // Output levels follow the next state so each output is a flop
      fast_on = (r_next.state != ST_SLEEP);                        // see RQ4
      r_next.xtal_en = fast_on && (!r_next.osc_sel || !r_next.osc_pd); // see RQ11
      r_next.rc_en   = fast_on && (r_next.osc_sel || !r_next.osc_pd || !xtal_stable_flag); // see RQ12
      r_next.clk_xtal = fast_on && !r_next.osc_sel && xtal_stable_flag; // see RQ12
      r_next.regulator_en = !((r_next.state == ST_SLEEP) && (r_next.cur_mode != MODE_LIGHT)); // see RQ5
      if ((r_next.state == ST_SLEEP) && (r_next.cur_mode == MODE_STANDBY)) begin
         r_next.slow_rc_en   = 1'b0;                               // see RQ6
         r_next.slow_xtal_en = 1'b0;
      end else begin
         r_next.slow_rc_en   = !slow_osc_sel;                      // see RQ1
         r_next.slow_xtal_en = slow_osc_sel;
      end
      r_next.cpu_clk_en  = (r_next.state == ST_ACTIVE) && !r_next.rsvd; // see RQ2
      r_next.irq_block   = (r_next.mode != MODE_CPU_IDLE);         // see RQ15
      r_next.usb_clear   = (r_next.state == ST_SLEEP) && (r_next.cur_mode != MODE_LIGHT); // see RQ22
      r_next.idle_status = (r_next.state == ST_CPU_IDLE);
   end

   // Sleep entry changes only the state and mode fields (mode cleared, cur_mode loaded); only sys_rst reinitialises the registers
   always_ff @(posedge ref_clk or posedge sys_rst) begin           // see RQ21
      if (sys_rst) begin                                           // see RQ9
         r_reg              <= '0;
         r_reg.state        <= ST_ACTIVE;
         r_reg.mode         <= MODE_RST;
         r_reg.osc_pd       <= OSC_PD_RST;
         r_reg.osc_sel      <= OSC_SEL_RST;
         r_reg.spare        <= PWR_CTRL_RST[SPARE_LSB +: 6];
         r_reg.rsvd         <= PWR_CTRL_RST[RSVD_BIT];
         r_reg.cpu_clk_en   <= 1'b1;
         r_reg.rc_en        <= 1'b1;
         r_reg.slow_rc_en   <= 1'b1;
         r_reg.regulator_en <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   pmc_seq_timer #(
      .W       (SEQ_W)
   ) u_seq (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .start   (seq_start),
      .length  (seq_len),
      .done    (seq_done)
   );

   assign prdata            = r_reg.prdata;
   assign pready            = r_reg.pready;
   assign pslverr           = r_reg.pslverr;
   assign cpu_clk_en        = r_reg.cpu_clk_en;
   assign fast_xtal_osc_en  = r_reg.xtal_en;
   assign fast_rc_osc_en    = r_reg.rc_en;
   assign slow_rc_osc_en    = r_reg.slow_rc_en;
   assign slow_xtal_osc_en  = r_reg.slow_xtal_en;
   assign regulator_en      = r_reg.regulator_en;
   assign sys_clk_from_xtal = r_reg.clk_xtal;
   assign io_hold           = r_reg.io_hold;
   assign wake_irq_block    = r_reg.irq_block;
   assign usb_state_clear   = r_reg.usb_clear;
   assign cpu_idle_status   = r_reg.idle_status;

endmodule : pmc_power_ctrl

// File: dv/pmc_power_ctrl_monitor.sv
`timescale 1ns/1ps
module pmc_power_ctrl_monitor
   import pmc_pkg::*;
#(
   parameter int LIGHT_CYC = LIGHT_SEQ_CYC,
   parameter int DEEP_CYC  = DEEP_SEQ_CYC
) (
   // Clock and reset
   input wire logic                       ref_clk,
   input wire logic                       sys_rst,
   // APB
   input wire logic [pmc_pkg::APB_AW-1:0] paddr,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [pmc_pkg::APB_DW-1:0] pwdata,
   input wire logic                       pready,
   // Power status
   input wire logic                       any_irq,
   input wire logic                       cpu_clk_en,
   input wire logic                       fast_xtal_osc_en,
   input wire logic                       fast_rc_osc_en,
   input wire logic                       slow_rc_osc_en,
   input wire logic                       slow_xtal_osc_en,
   input wire logic                       regulator_en,
   input wire logic                       io_hold,
   input wire logic                       wake_irq_block,
   input wire logic                       cpu_idle_status
);
   localparam logic [11:0] CFG_ADDR = {SLEEP_CFG_IDX, 2'b00};
   logic       fast_on;
   logic [7:0] seq_cnt;
   assign fast_on = fast_xtal_osc_en | fast_rc_osc_en;
   // Cycles of power-down spent before the fast oscillators stop
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) seq_cnt <= 8'h00;
      else if (!io_hold) seq_cnt <= 8'h00;
      else if (fast_on && seq_cnt != 8'hFF) seq_cnt <= seq_cnt + 8'h01;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_active; cpu_clk_en && !io_hold |-> regulator_en && fast_on && (slow_rc_osc_en ^ slow_xtal_osc_en);
   endproperty
   a_active: assert property (p_active) else $error("active config wrong");
   property p_idle; cpu_idle_status && $past(cpu_idle_status) |-> !cpu_clk_en && regulator_en && fast_on && !io_hold;
   endproperty
   a_idle: assert property (p_idle) else $error("idle config wrong");
   property p_idle_wake; cpu_idle_status && any_irq |-> ##[1:2] (cpu_clk_en && !cpu_idle_status); endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle not left");
   property p_fast_off; !fast_on |-> io_hold && !cpu_clk_en && !wake_irq_block; endproperty
   a_fast_off: assert property (p_fast_off) else $error("sleep outputs wrong");
   property p_reg_off; !regulator_en |-> io_hold && !fast_on; endproperty
   a_reg_off: assert property (p_reg_off) else $error("regulator off outside sleep");
   property p_standby; !slow_rc_osc_en && !slow_xtal_osc_en |-> !regulator_en && !fast_on; endproperty
   a_standby: assert property (p_standby) else $error("standby outputs wrong");
   property p_block;
      psel && penable && pready && pwrite && paddr == CFG_ADDR && pwdata[1:0] != 2'b00 |-> ##[1:2] wake_irq_block;
   endproperty
   a_block: assert property (p_block) else $error("wake not blocked");
   property p_seq; !fast_on && $past(fast_on) |-> seq_cnt >= (regulator_en ? LIGHT_CYC - 1 : DEEP_CYC - 1);
   endproperty
   a_seq: assert property (p_seq) else $error("power-down too short");
   c_idle: cover property (cpu_idle_status);
   c_light: cover property (!fast_on && regulator_en);
   c_standby: cover property (!slow_rc_osc_en && !slow_xtal_osc_en);
endmodule : pmc_power_ctrl_monitor
bind pmc_power_ctrl pmc_power_ctrl_monitor #(.LIGHT_CYC(LIGHT_CYC), .DEEP_CYC(DEEP_CYC)) u_mon (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pready(pready), .any_irq(any_irq), .cpu_clk_en(cpu_clk_en),
   .fast_xtal_osc_en(fast_xtal_osc_en), .fast_rc_osc_en(fast_rc_osc_en), .slow_rc_osc_en(slow_rc_osc_en),
   .slow_xtal_osc_en(slow_xtal_osc_en), .regulator_en(regulator_en), .io_hold(io_hold),
   .wake_irq_block(wake_irq_block), .cpu_idle_status(cpu_idle_status));

// File: dv/pmc_osc_model.sv
`timescale 1ns/1ps
module pmc_osc_model #(
   parameter int XTAL_DLY = 8
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // Oscillator power and status
   input  wire logic fast_xtal_osc_en,
   input  wire logic fast_rc_osc_en,
   output logic      xtal_stable_flag,
   output logic      rc_stable_flag
);
   logic [7:0] xtal_cnt;
   logic [7:0] rc_cnt;
   // Start-up restarts whenever power is removed, so status drops at once
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         xtal_cnt <= 8'h00;
         rc_cnt   <= 8'h00;
      end else begin
         xtal_cnt <= fast_xtal_osc_en ? xtal_cnt + {7'h00, xtal_cnt < 8'hFF} : 8'h00;
         rc_cnt   <= fast_rc_osc_en ? rc_cnt + {7'h00, rc_cnt < 8'h02} : 8'h00;
      end
   end
   assign xtal_stable_flag = fast_xtal_osc_en && xtal_cnt >= 8'(XTAL_DLY);
   assign rc_stable_flag   = fast_rc_osc_en && rc_cnt >= 8'h02;
endmodule : pmc_osc_model

// File: dv/pmc_power_ctrl_tb.sv
`timescale 1ns/1ps
module pmc_power_ctrl_tb;
   import pmc_pkg::*;
   localparam logic [11:0] PWR_ADDR = {PWR_CTRL_IDX, 2'b00};
   localparam logic [11:0] CFG_ADDR = {SLEEP_CFG_IDX, 2'b00};
   localparam logic [11:0] CLK_ADDR = {CLK_CTRL_IDX, 2'b00};
   logic        ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, seen, xsel = 1'b0;
   logic        ext_port_irq = 1'b0, sleep_timer_irq = 1'b0, any_irq = 1'b0, slow_osc_sel = 1'b0;
   logic        xtal_stable_flag, rc_stable_flag, cpu_clk_en, fast_xtal_osc_en, fast_rc_osc_en, slow_rc_osc_en;
   logic        slow_xtal_osc_en, regulator_en, sys_clk_from_xtal, io_hold, wake_irq_block, usb_state_clear;
   logic        cpu_idle_status;
   logic [7:0]  spare = 8'h00;
   int          fails = 0, tests_run = 0, seed = 14347;

   always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

   pmc_power_ctrl #(.LIGHT_CYC(3), .DEEP_CYC(6)) DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_port_irq(ext_port_irq),
      .sleep_timer_irq(sleep_timer_irq), .any_irq(any_irq), .xtal_stable_flag(xtal_stable_flag),
      .rc_stable_flag(rc_stable_flag), .slow_osc_sel(slow_osc_sel), .cpu_clk_en(cpu_clk_en),
      .fast_xtal_osc_en(fast_xtal_osc_en), .fast_rc_osc_en(fast_rc_osc_en), .slow_rc_osc_en(slow_rc_osc_en),
      .slow_xtal_osc_en(slow_xtal_osc_en), .regulator_en(regulator_en), .sys_clk_from_xtal(sys_clk_from_xtal),
      .io_hold(io_hold), .wake_irq_block(wake_irq_block), .usb_state_clear(usb_state_clear),
      .cpu_idle_status(cpu_idle_status));
   pmc_osc_model u_osc (.ref_clk(ref_clk), .sys_rst(sys_rst), .fast_xtal_osc_en(fast_xtal_osc_en),
      .fast_rc_osc_en(fast_rc_osc_en), .xtal_stable_flag(xtal_stable_flag), .rc_stable_flag(rc_stable_flag));

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fails++;
         test_done();
      end
   endtask : apb

   // 0: back in active, 1: asleep, 2: system clock on crystal
   task automatic wait_until(input int sel);
      int   n;
      logic s;
      n = 0;
      s = 1'b0;
      while (s !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         #1;
         n++;
         case (sel)
            0: s = cpu_clk_en & ~io_hold;
            1: s = ~(fast_xtal_osc_en | fast_rc_osc_en);
            default: s = sys_clk_from_xtal;
         endcase
      end
      if (s !== 1'b1) begin
         fails++;
         test_done();
      end
   endtask : wait_until

   // Regulator, slow RC, slow crystal, USB clear while asleep
   function automatic logic [3:0] exp_sleep(input logic [1:0] m, input logic sel);
      exp_sleep = {m == MODE_LIGHT, m != MODE_STANDBY && !sel, m != MODE_STANDBY && sel, m != MODE_LIGHT};
   endfunction : exp_sleep

   task automatic run_sleep(input logic [1:0] m, input logic by_port);
      apb(1'b1, CFG_ADDR, {29'h0, 1'b1, m});
      @(posedge ref_clk);
      #1;
      chk(wake_irq_block, 1'b1);
      apb(1'b1, PWR_ADDR, {24'h0, spare[7:2], 2'b01});
      wait_until(1);
      chk({regulator_en, slow_rc_osc_en, slow_xtal_osc_en, usb_state_clear}, exp_sleep(m, slow_osc_sel));
      chk({io_hold, cpu_clk_en, wake_irq_block}, 3'b100);
      if (m == MODE_STANDBY) begin
         @(posedge ref_clk);
         sleep_timer_irq <= 1'b1;
         repeat (4) @(posedge ref_clk);
         #1;
         chk({io_hold, fast_rc_osc_en}, 2'b10);
      end
      @(posedge ref_clk);
      sleep_timer_irq <= !by_port;
      ext_port_irq <= by_port;
      wait_until(0);
      chk(sys_clk_from_xtal & ~xtal_stable_flag, 1'b0);
      chk(xsel ? fast_xtal_osc_en : fast_rc_osc_en, 1'b1);
      @(posedge ref_clk);
      sleep_timer_irq <= 1'b0;
      ext_port_irq <= 1'b0;
      apb(1'b0, CFG_ADDR, 32'h0);
      chk(rd[1:0], MODE_CPU_IDLE);
      apb(1'b0, PWR_ADDR, 32'h0);
      chk(rd[7:0], spare);
      $display("test sleep mode %0d done", m);
   endtask : run_sleep

   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk({cpu_clk_en, regulator_en, fast_rc_osc_en, fast_xtal_osc_en, io_hold}, 5'b11100);
      apb(1'b0, CFG_ADDR, 32'h0);
      chk(rd & 32'h7, {29'h0, OSC_PD_RST, MODE_RST});
      apb(1'b0, CLK_ADDR, 32'h0);
      chk(rd & 32'h1, {31'h0, OSC_SEL_RST});
      apb(1'b0, 12'hFFC, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      for (int i = 0; i < 8; i++) begin
         spare = 8'($random(seed)) & 8'hFC;
         apb(1'b1, PWR_ADDR, {24'h0, spare});
         apb(1'b0, PWR_ADDR, 32'h0);
         chk(rd, {24'h0, spare});
      end
      $display("test registers done");
      apb(1'b1, CFG_ADDR, {29'h0, 1'b1, MODE_CPU_IDLE});
      apb(1'b1, PWR_ADDR, {24'h0, spare[7:2], 2'b01});
      repeat (2) @(posedge ref_clk);
      #1;
      chk({cpu_idle_status, cpu_clk_en, regulator_en, io_hold}, 4'b1010);
      @(posedge ref_clk);
      any_irq <= 1'b1;
      @(posedge ref_clk);
      any_irq <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk({cpu_idle_status, cpu_clk_en}, 2'b01);
      $display("test idle done");
      for (int m = 1; m < 4; m++) begin
         @(posedge ref_clk);
         slow_osc_sel <= 1'($random(seed));
         run_sleep(2'(m), m[0]);
      end
      apb(1'b1, CFG_ADDR, {29'h0, 1'b1, MODE_DEEP});
      apb(1'b1, PWR_ADDR, 32'h1);
      ext_port_irq <= 1'b1;
      seen = 1'b0;
      repeat (10) begin
         @(posedge ref_clk);
         #1;
         if (!(fast_xtal_osc_en | fast_rc_osc_en)) seen = 1'b1;
      end
      wait_until(0);
      chk(seen, 1'b0);
      @(posedge ref_clk);
      ext_port_irq <= 1'b0;
      apb(1'b0, CFG_ADDR, 32'h0);
      chk(rd[1:0], MODE_CPU_IDLE);
      apb(1'b1, CFG_ADDR, {29'h0, 1'b1, MODE_LIGHT});
      apb(1'b1, CFG_ADDR, 32'h4);
      @(posedge ref_clk);
      #1;
      chk(wake_irq_block, 1'b0);
      $display("test abort done");
      apb(1'b1, CLK_ADDR, 32'h0);
      xsel = 1'b1;
      wait_until(2);
      chk({fast_xtal_osc_en, xtal_stable_flag}, 2'b11);
      run_sleep(MODE_LIGHT, 1'b1);
      wait_until(2);
      apb(1'b1, CFG_ADDR, {29'h0, 1'b1, MODE_STANDBY});
      apb(1'b1, PWR_ADDR, 32'h1);
      wait_until(1);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk({cpu_clk_en, io_hold, regulator_en, fast_rc_osc_en}, 4'b1011);
      $display("test reset in sleep done");
      test_done();
   end
endmodule : pmc_power_ctrl_tb
